/* logic/wake_thermal_top.sv */
// Register file, pin synchronisers and thermal restart control.
// Assumes an APB master on mclk_i and asynchronous temperature pins.
//
// The implementer's own choice: the APB register port.
module wake_thermal_top
  import wake_pkg::*;
(
  // Clock and resets
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        core_rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [15:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Oscillator tick and temperature comparators
  input  wire logic        lfo_tick_i,
  input  wire logic        temp_hot_i,
  input  wire logic        temp_cold_i,
  input  wire logic        temp_normal_i,
  // Core side
  output logic             wake_irq_o,
  output logic             core_reset_o,
  output logic             deepest_stop_o
);
  timer_if tif ();

  logic [3:0] sync2;
  logic       tick_prev;
  logic [5:0] prescale;
  logic [5:0] wake_field;
  logic       wake_off;
  logic [5:0] reset_field;
  logic       wake_flag;
  logic       reset_flag;
  logic       stat_sel;
  logic       th_enable;
  logic       th_high;
  logic       oor_status;
  thermal_t   th_state;
  thermal_t   next_th_state;

  ////////////////////////////////////////////////////////////////////
  // Address decode helper
  function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
    return (a[ADDR_LSB-1:0] == 2'b00) && (a[15:ADDR_LSB] == idx[13:0]);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two flops each
  wire [3:0] pins = {temp_normal_i, temp_cold_i, temp_hot_i, lfo_tick_i};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      logic meta_ff, stable_ff;
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          meta_ff   <= 1'b0;
          stable_ff <= 1'b0;
        end else begin
          meta_ff   <= pins[gi];
          stable_ff <= meta_ff;
        end
      end
      assign sync2[gi] = stable_ff;
    end
  endgenerate

  // Tick edge from the synchronised oscillator
  always_ff @(posedge mclk_i) begin
    if (rst_i)
      tick_prev <= 1'b0;
    else
      tick_prev <= sync2[0];
  end

  wire tick   = sync2[0] && !tick_prev;
  wire hot    = sync2[1];
  wire cold   = sync2[2];
  wire normal = sync2[3];

  ////////////////////////////////////////////////////////////////////
  // Reset sources and bus strobes
  wire any_rst = rst_i || core_rst_i || core_reset_o;
  wire setup   = psel_i && !penable_i && !pready_o;
  wire wr      = psel_i && penable_i && pready_o && pwrite_i;
  wire wr_div  = wr && hit(paddr_i, IDX_DIV);
  wire wr_wake = wr && hit(paddr_i, IDX_WAKE);
  wire wr_rst  = wr && hit(paddr_i, IDX_RST);
  wire wr_stat = wr && hit(paddr_i, IDX_STAT);
  wire wr_opt  = wr && hit(paddr_i, IDX_OPT);
  wire mapped  = hit(paddr_i, IDX_DIV) || hit(paddr_i, IDX_WAKE)
              || hit(paddr_i, IDX_RST) || hit(paddr_i, IDX_STAT)
              || hit(paddr_i, IDX_OPT) || hit(paddr_i, IDX_TEST);

  ////////////////////////////////////////////////////////////////////
  // Count writes: zero handling and restart on change
  wire [5:0] wdat       = pwdata_i[5:0];
  wire       wake_zero  = (wdat == COUNT_ZERO);
  wire       wake_ok    = !(wake_zero && reset_field == COUNT_ZERO);
  wire [5:0] new_wake   = wake_zero ? COUNT_PRESET : wdat;
  wire       rst_ok     = !(wake_zero && wake_off);
  wire       wake_chg   = wr_wake && wake_ok
                       && (new_wake != wake_field || wake_zero != wake_off);
  wire       rst_chg    = wr_rst && rst_ok && (wdat != reset_field);
  wire       wake_ack   = wr_wake && pwdata_i[ACK_BIT];
  wire       rst_ack    = wr_rst && pwdata_i[ACK_BIT];
  wire       next_wake_flag = tif.wake_evt
                           || (wake_flag && !wake_ack);
  wire       next_rst_flag  = tif.reset_evt
                           || (reset_flag && !rst_ack);

  ////////////////////////////////////////////////////////////////////
  // Prescale field, power-on reset only
  always_ff @(posedge mclk_i) begin
    if (rst_i)
      prescale <= PRESCALE_POR;
    else if (wr_div)
      prescale <= wdat;
  end

  // Count fields and disable bit
  always_ff @(posedge mclk_i) begin
    if (any_rst) begin
      wake_field  <= COUNT_PRESET;
      wake_off    <= 1'b0;
      reset_field <= COUNT_PRESET;
    end else begin
      if (wake_chg) begin
        wake_field <= new_wake;
        wake_off   <= wake_zero;
      end
      if (rst_chg)
        reset_field <= wdat;
    end
  end

  // Event flags, set wins over acknowledge
  always_ff @(posedge mclk_i) begin
    if (any_rst) begin
      wake_flag  <= 1'b0;
      reset_flag <= 1'b0;
    end else begin
      wake_flag  <= next_wake_flag;
      reset_flag <= next_rst_flag;
    end
  end

  // Readback select and option bits
  always_ff @(posedge mclk_i) begin
    if (any_rst) begin
      stat_sel  <= 1'b0;
      th_enable <= 1'b0;
      th_high   <= 1'b0;
    end else begin
      if (wr_stat)
        stat_sel <= pwdata_i[SEL_BIT];
      if (wr_opt) begin
        th_enable <= pwdata_i[EN_BIT] && oor_status;
        th_high   <= pwdata_i[HI_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Out-of-range status tracking
  wire beyond = th_high ? hot : cold;

  always_ff @(posedge mclk_i) begin
    if (any_rst)
      oor_status <= 1'b1;
    else if (beyond)
      oor_status <= 1'b1;
    else if (normal)
      oor_status <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // Thermal restart state machine
  always_comb begin
    next_th_state = th_state;
    unique case (th_state)
      TH_RUN:
        if (th_enable && beyond)
          next_th_state = TH_STOP;
      TH_STOP:
        if (th_enable && oor_status && normal)
          next_th_state = TH_RESTART;
      TH_RESTART:
        next_th_state = TH_RUN;
      default:
        next_th_state = TH_RUN;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (any_rst)
      th_state <= TH_RUN;
    else
      th_state <= next_th_state;
  end

  ////////////////////////////////////////////////////////////////////
  // Timer core hookup
  assign tif.tick          = tick;
  assign tif.prescale      = prescale;
  assign tif.wake_field    = wake_field;
  assign tif.wake_off      = wake_off;
  assign tif.reset_field   = reset_field;
  assign tif.wake_restart  = wake_chg;
  assign tif.reset_restart = rst_chg;
  assign tif.suppress      = th_enable && oor_status;

  wake_timer u_timer (
    .mclk_i (mclk_i),
    .rst_i  (any_rst),
    .tif    (tif.timer)
  );

  ////////////////////////////////////////////////////////////////////
  // Core side outputs, all registered
  always_ff @(posedge mclk_i) begin
    if (any_rst) begin
      wake_irq_o     <= 1'b0;
      core_reset_o   <= 1'b0;
      deepest_stop_o <= 1'b0;
    end else begin
      wake_irq_o     <= next_wake_flag;
      core_reset_o   <= tif.reset_evt
                     || (next_th_state == TH_RESTART);
      deepest_stop_o <= (next_th_state == TH_STOP);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data mux
  wire [5:0] cnt_sel = stat_sel ? tif.reset_count : tif.wake_count;
  wire [7:0] rd_byte =
    hit(paddr_i, IDX_DIV)  ? {2'b00, prescale} :
    hit(paddr_i, IDX_WAKE) ? {wake_flag, 1'b0, wake_field} :
    hit(paddr_i, IDX_RST)  ? {reset_flag, 1'b0, reset_field} :
    hit(paddr_i, IDX_STAT) ? {stat_sel, 1'b0, cnt_sel} :
    hit(paddr_i, IDX_OPT)  ? 8'(({7'h00, th_enable} << EN_BIT)
                              | ({7'h00, th_high} << HI_BIT)) :
    hit(paddr_i, IDX_TEST) ? 8'({7'h00, oor_status} << OOR_BIT) :
    8'h00;

  // APB answer one cycle after setup
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o <= setup;
      if (setup) begin
        pslverr_o <= !mapped;
        prdata_o  <= {24'h00_0000, rd_byte};
      end else if (pready_o) begin
        pslverr_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_por_prescale;
    rst_i |=> prescale == PRESCALE_POR;
  endproperty
  a_por_prescale: assert property (disable iff (1'b0) p_por_prescale)
    else $error("prescale not preset at power-on");

  property p_stop_enter;
    !any_rst && th_state == TH_RUN && th_enable && beyond |=> deepest_stop_o;
  endproperty
  a_stop_enter: assert property (p_stop_enter)
    else $error("deepest stop not entered");

  property p_restart;
    !any_rst && th_state == TH_STOP && th_enable && oor_status && normal
      |=> core_reset_o ##1 (!th_enable && !deepest_stop_o);
  endproperty
  a_restart: assert property (p_restart)
    else $error("thermal restart missing");

  property p_restart_armed;
    th_state == TH_RESTART |-> $past(oor_status) && $past(th_enable);
  endproperty
  a_restart_armed: assert property (p_restart_armed)
    else $error("restart without re-arm");

  property p_reset_sets_oor;
    core_reset_o |=> oor_status && !th_enable && !th_high;
  endproperty
  a_reset_sets_oor: assert property (p_reset_sets_oor)
    else $error("core reset state wrong");

  property p_enable_refused;
    !any_rst && wr_opt && pwdata_i[EN_BIT] && !oor_status |=> !th_enable;
  endproperty
  a_enable_refused: assert property (p_enable_refused)
    else $error("enable set while in range");

  property p_oor_rise;
    !any_rst && beyond |=> oor_status;
  endproperty
  a_oor_rise: assert property (p_oor_rise)
    else $error("status did not rise");

  property p_irq_unmasked;
    !any_rst && tif.wake_evt |=> wake_irq_o;
  endproperty
  a_irq_unmasked: assert property (p_irq_unmasked)
    else $error("wake event not on irq");

  property p_ack_clears;
    !any_rst && wake_ack && !tif.wake_evt |=> !wake_irq_o;
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("acknowledge did not clear");

  property p_never_both_off;
    !(wake_off && reset_field == COUNT_ZERO);
  endproperty
  a_never_both_off: assert property (p_never_both_off)
    else $error("wake and reset both disabled");

  property p_suppress;
    tif.suppress |-> !tif.wake_evt && !tif.reset_evt;
  endproperty
  a_suppress: assert property (p_suppress)
    else $error("event while suppressed");

  property p_precedence;
    tif.reset_evt |-> !tif.wake_evt;
  endproperty
  a_precedence: assert property (p_precedence)
    else $error("wake with periodic reset");

  property p_count_clear;
    !any_rst && tif.wake_evt |=> tif.wake_count == COUNT_ZERO;
  endproperty
  a_count_clear: assert property (p_count_clear)
    else $error("counter not cleared");

  c_wake: cover property (!wake_irq_o ##1 wake_irq_o);
  c_periodic_rst: cover property (tif.reset_evt ##1 core_reset_o);
  c_stop: cover property (!deepest_stop_o ##1 deepest_stop_o);
  c_restart: cover property (deepest_stop_o ##[1:8] core_reset_o);
endmodule : wake_thermal_top

/* logic/wake_pkg.sv */
// Constants, register map and types of the wakeup timer and thermal restart.
// Assumes APB byte addresses equal four times the register index.
//
// How it works
// - Armed restart unit pulses core reset when temperature returns to normal.
// - Restart enable is option bit 3 at index 1802; core reset clears it.
// - High select picks hot threshold, else cold; core reset clears it.
// - Enabled unit reaching the selected extreme holds the deepest stop state.
// - No restart unless out-of-range status shows the re-arm range was left.
// - Out-of-range status is test bit 0 at index 180F; core reset sets it.
// - Status 1 allows arming; status 0 refuses setting the enable bit.
// - Status rises past the re-arm threshold, falls on entering reset range.
// - Timer raises wake interrupt and optional periodic reset from 1 ms tick.
// - Oscillator tick path and timer always run; no control stops them.
// - Wakeup and periodic reset can never both be disabled.
// - Wake interrupt output has no mask once generated.
// - Prescaler with 64 settings feeds two cascaded 6-bit counters.
// - Prescaler divides ticks by 504 plus 16 times the prescale field.
// - Wake counter counts prescaled pulses; reset counter counts wake pulses.
// - Counters fire at the programmed count and clear to zero.
// - Reset and wakeup in one cycle: only the reset is issued.
// - Armed and out of range: both events suppressed, counters keep running.
// - Status select bit chooses which counter is read back.
// - Divider bits 7:6 read zero; field resets to 31 only at power-on.
// - Zero wake count disables wakeup, presets 63; refused if reset count zero.
// - Writing one to acknowledge clears the wake flag; acknowledge reads zero.
package wake_pkg;
  // Register indices
  localparam logic [15:0] IDX_DIV  = 16'h0038;
  localparam logic [15:0] IDX_WAKE = 16'h0039;
  localparam logic [15:0] IDX_RST  = 16'h003A;
  localparam logic [15:0] IDX_STAT = 16'h003B;
  localparam logic [15:0] IDX_OPT  = 16'h1802;
  localparam logic [15:0] IDX_TEST = 16'h180F;
  localparam int unsigned ADDR_LSB = 2;
  // Field positions
  localparam int unsigned FLAG_BIT = 7;
  localparam int unsigned ACK_BIT  = 6;
  localparam int unsigned SEL_BIT  = 7;
  localparam int unsigned EN_BIT   = 3;
  localparam int unsigned HI_BIT   = 2;
  localparam int unsigned OOR_BIT  = 0;
  // Reset values and divider figures
  localparam logic [5:0]  PRESCALE_POR = 6'h1F;
  localparam logic [5:0]  COUNT_PRESET = 6'h3F;
  localparam logic [5:0]  COUNT_ZERO   = 6'h00;
  localparam logic [10:0] PRE_BASE     = 11'h1F8;
  localparam int unsigned PRE_SHIFT    = 4;
  // Thermal restart states
  typedef enum logic [1:0] {
    TH_RUN     = 2'b00,
    TH_STOP    = 2'b01,
    TH_RESTART = 2'b10
  } thermal_t;
endpackage : wake_pkg

/* logic/timer_if.sv */
// Signals between register logic and the timer core.
// Assumes both ends sit on the same clock.
interface timer_if;
  logic       tick;
  logic [5:0] prescale;
  logic [5:0] wake_field;
  logic       wake_off;
  logic [5:0] reset_field;
  logic       wake_restart;
  logic       reset_restart;
  logic       suppress;
  logic       wake_evt;
  logic       reset_evt;
  logic [5:0] wake_count;
  logic [5:0] reset_count;
  modport timer (input tick, prescale, wake_field, wake_off, reset_field,
                 wake_restart, reset_restart, suppress,
                 output wake_evt, reset_evt, wake_count, reset_count);
  modport ctrl (output tick, prescale, wake_field, wake_off, reset_field,
                wake_restart, reset_restart, suppress,
                input wake_evt, reset_evt, wake_count, reset_count);
endinterface : timer_if

/* logic/wake_timer.sv */
// Prescaler and the two cascaded counters of the wakeup timer.
// Assumes a one-cycle tick per oscillator period, already synchronised.
module wake_timer
  import wake_pkg::*;
(
  // Clock and core reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Control side
  timer_if.timer   tif
);
  logic [10:0] pre_cnt;
  logic [5:0]  wake_cnt;
  logic [5:0]  rst_cnt;
  wire  [10:0] pre_last;
  wire         wclk;
  wire         wake_hit;
  wire         rst_hit;

  ////////////////////////////////////////////////////////////////////
  // Terminal counts and events
  assign pre_last = PRE_BASE + (11'(tif.prescale) << PRE_SHIFT)
                  - 11'h001;
  assign wclk     = tif.tick && (pre_cnt == pre_last);
  assign wake_hit = wclk && (wake_cnt + 6'h01 == tif.wake_field);
  assign rst_hit  = wake_hit && (tif.reset_field != COUNT_ZERO)
                 && (rst_cnt + 6'h01 == tif.reset_field);
  // Suppression gates events only, never counting
  assign tif.reset_evt = rst_hit && !tif.suppress;
  assign tif.wake_evt  = wake_hit && !tif.wake_off && !tif.suppress
                      && !rst_hit;
  assign tif.wake_count  = wake_cnt;
  assign tif.reset_count = rst_cnt;

  ////////////////////////////////////////////////////////////////////
  // Prescaler, free running from the tick
  always_ff @(posedge mclk_i) begin
    if (rst_i || wclk)
      pre_cnt <= 11'h000;
    else if (tif.tick)
      pre_cnt <= pre_cnt + 11'h001;
  end

  // Wake counter, cleared on its event or a new count
  always_ff @(posedge mclk_i) begin
    if (rst_i || tif.wake_restart || wake_hit)
      wake_cnt <= COUNT_ZERO;
    else if (wclk)
      wake_cnt <= wake_cnt + 6'h01;
  end

  // Reset counter, clocked by wake terminal counts
  always_ff @(posedge mclk_i) begin
    if (rst_i || tif.reset_restart || rst_hit)
      rst_cnt <= COUNT_ZERO;
    else if (wake_hit)
      rst_cnt <= rst_cnt + 6'h01;
  end
endmodule : wake_timer

/* testbench/core_model.sv */
// Behavioural core beside the wakeup block: counts interrupts and resets.
// Assumes every input is synchronous to mclk_i.
module core_model (
  // Clock and power-on reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // Block outputs seen by the core
  input  wire logic       wake_irq_i,
  input  wire logic       core_reset_i,
  // Bench request and core reset to the block
  input  wire logic       reset_req_i,
  output logic            core_rst_o,
  // Event counts for the bench
  output logic [7:0]      irq_cnt_o,
  output logic [7:0]      rst_cnt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic irq_q;
  ////////////////////////////////////////////////////////////////////////////
  // Interrupt taken on every rising edge, no mask in the core
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_q      <= 1'b0;
      irq_cnt_o  <= 8'h00;
      rst_cnt_o  <= 8'h00;
      core_rst_o <= 1'b0;
    end else begin
      irq_q      <= wake_irq_i;
      core_rst_o <= reset_req_i;
      if (wake_irq_i && !irq_q) irq_cnt_o <= irq_cnt_o + 8'h01;
      if (core_reset_i) rst_cnt_o <= rst_cnt_o + 8'h01;
    end
  end
endmodule : core_model

/* testbench/periodic_wakeup_thermal_restart_tb.sv */
// Self-checking bench of the wakeup timer and thermal restart block.
// Assumes the one-cycle APB answer and synchronised pins of the design.
module periodic_wakeup_thermal_restart_tb
  import wake_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] M = 32'hFFFFFFFF;
  logic        mclk_i, rst_i, core_rst, psel, penable, pwrite, pready, pslverr;
  logic        lfo_tick, temp_hot, temp_cold, temp_normal, reset_req, err;
  logic        wake_irq, core_reset, deepest_stop;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  irq_cnt, rst_cnt;
  logic [2:0]  outs;
  int          error_cnt, compares, cyc;
  assign outs = {core_reset, deepest_stop, wake_irq};
  ////////////////////////////////////////////////////////////////////////////
  // Design and core model
  wake_thermal_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .core_rst_i(core_rst),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .lfo_tick_i(lfo_tick), .temp_hot_i(temp_hot), .temp_cold_i(temp_cold),
    .temp_normal_i(temp_normal), .wake_irq_o(wake_irq), .core_reset_o(core_reset),
    .deepest_stop_o(deepest_stop));
  core_model core (.mclk_i(mclk_i), .rst_i(rst_i), .wake_irq_i(wake_irq),
    .core_reset_i(core_reset), .reset_req_i(reset_req), .core_rst_o(core_rst),
    .irq_cnt_o(irq_cnt), .rst_cnt_o(rst_cnt));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, 40 ns period
  always #20 mclk_i = ~mclk_i;
  // Hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      $display("[FAIL] %0t run did not finish", $time);
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // One APB transfer, then one idle cycle
  task apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= 16'(idx << ADDR_LSB);
    pwdata  <= {24'h000000, wd};
    @(posedge mclk_i);
    penable <= 1'b1;
    do begin
      @(posedge mclk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_i);
  endtask : apb
  task rd_chk(input logic [15:0] idx, input logic [31:0] exp, input logic [31:0] mask);
    apb(1'b0, idx, 8'h00);
    chk(rd & mask, exp, "register read");
  endtask : rd_chk
  // Oscillator ticks, four clocks each
  task ticks(input int n);
    repeat (n) begin
      lfo_tick <= 1'b1;
      repeat (2) @(posedge mclk_i);
      lfo_tick <= 1'b0;
      repeat (2) @(posedge mclk_i);
    end
  endtask : ticks
  // Bounded wait for one block output
  task wait_out(input int b);
    int n;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (outs[b] !== 1'b1 && n < 40);
    chk({31'h0, outs[b]}, 32'h1, "output wait");
  endtask : wait_out
  task core_rst_pulse;
    reset_req <= 1'b1;
    @(posedge mclk_i);
    reset_req <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask : core_rst_pulse
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {mclk_i, psel, penable, pwrite, lfo_tick, temp_hot, temp_cold} = '0;
    {temp_normal, reset_req, paddr, pwdata} = '0;
    rst_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    // Reset values and an unmapped place
    rd_chk(IDX_DIV, 32'h1F, M);
    rd_chk(IDX_WAKE, 32'h3F, M);
    rd_chk(IDX_TEST, 32'h01, M);
    rd_chk(IDX_OPT, 32'h00, M);
    apb(1'b0, 16'h0100, 8'h00);
    chk({31'h0, err}, 32'h1, "unmapped error");
    // Divider field width, then shortest prescale
    apb(1'b1, IDX_DIV, 8'hFF);
    rd_chk(IDX_DIV, 32'h3F, M);
    apb(1'b1, IDX_DIV, 8'h00);
    // Wake after two periods of 504 ticks
    apb(1'b1, IDX_WAKE, 8'h02);
    ticks(1007);
    repeat (6) @(posedge mclk_i);
    chk({31'h0, wake_irq}, 32'h0, "early wake");
    ticks(1);
    wait_out(0);
    apb(1'b1, IDX_STAT, 8'h00);
    rd_chk(IDX_STAT, 32'h00, 32'h3F);
    apb(1'b1, IDX_STAT, 8'h80);
    rd_chk(IDX_STAT, 32'h01, 32'h3F);
    apb(1'b1, IDX_WAKE, 8'h02);
    rd_chk(IDX_WAKE, 32'h82, M);
    apb(1'b1, IDX_WAKE, 8'h42);
    rd_chk(IDX_WAKE, 32'h02, M);
    chk({31'h0, wake_irq}, 32'h0, "irq after ack");
    // Wakeup and periodic reset may not both be off
    apb(1'b1, IDX_RST, 8'h00);
    rd_chk(IDX_RST, 32'h00, 32'h3F);
    apb(1'b1, IDX_WAKE, 8'h00);
    rd_chk(IDX_WAKE, 32'h02, 32'h3F);
    // Core reset keeps the prescale field
    core_rst_pulse();
    rd_chk(IDX_DIV, 32'h00, M);
    rd_chk(IDX_RST, 32'h3F, M);
    // Zero wake count accepted while reset count is live, then reset zero refused
    apb(1'b1, IDX_WAKE, 8'h00);
    rd_chk(IDX_WAKE, 32'h3F, M);
    apb(1'b1, IDX_RST, 8'h00);
    rd_chk(IDX_RST, 32'h3F, M);
    // Reset and wake in one cycle: reset only
    apb(1'b1, IDX_WAKE, 8'h01);
    apb(1'b1, IDX_RST, 8'h01);
    ticks(504);
    repeat (6) @(posedge mclk_i);
    chk(32'(rst_cnt), 32'h1, "periodic reset");
    chk(32'(irq_cnt), 32'h1, "wake count");
    rd_chk(IDX_WAKE, 32'h3F, M);
    // Thermal restart from the hot side
    rd_chk(IDX_TEST, 32'h01, M);
    apb(1'b1, IDX_OPT, 8'h0C);
    rd_chk(IDX_OPT, 32'h0C, M);
    core_rst_pulse();
    rd_chk(IDX_OPT, 32'h00, M);
    apb(1'b1, IDX_OPT, 8'h0C);
    temp_hot <= 1'b1;
    wait_out(1);
    temp_hot    <= 1'b0;
    temp_normal <= 1'b1;
    wait_out(2);
    chk({31'h0, deepest_stop}, 32'h0, "stop after restart");
    repeat (4) @(posedge mclk_i);
    rd_chk(IDX_OPT, 32'h00, M);
    rd_chk(IDX_TEST, 32'h00, M);
    apb(1'b1, IDX_OPT, 8'h0C);
    rd_chk(IDX_OPT, 32'h04, M);
    temp_normal <= 1'b0;
    temp_hot    <= 1'b1;
    repeat (6) @(posedge mclk_i);
    rd_chk(IDX_TEST, 32'h01, M);
    // Low threshold ignores the hot side
    apb(1'b1, IDX_OPT, 8'h08);
    rd_chk(IDX_OPT, 32'h08, M);
    repeat (6) @(posedge mclk_i);
    chk({31'h0, deepest_stop}, 32'h0, "hot with low select");
    temp_cold <= 1'b1;
    wait_out(1);
    summarize();
  end
endmodule : periodic_wakeup_thermal_restart_tb
